// [shared/dmt_defines.svh]
// Constants of the debug-module test access logic
`ifndef DMT_DEFINES_SVH
`define DMT_DEFINES_SVH

// ==========================================================
// Test instruction codes
`define DMT_IR_W 4
`define DMT_IR_IDCODE 4'h2
`define DMT_IR_DEBUG_ACCESS 4'h6
`define DMT_IR_HALT_REQ 4'h7
`define DMT_IR_BYPASS 4'hf
`define DMT_IR_CAPTURE_LOW 2'h1

// ==========================================================
// Shifter and register widths
`define DMT_DR_W 16
`define DMT_CMD_W 8
`define DMT_CNT_W 8
`define DMT_SEL_W 2

// ==========================================================
// Debug command fields
`define DMT_OP_NONE 8'h00
`define DMT_OP_RD_BIT 7
`define DMT_OP_RS_MSB 1
`define DMT_OP_RS_LSB 0
`define DMT_OP_MID_MSB 6
`define DMT_OP_MID_LSB 2
`define DMT_RS_COUNTER 2'h1
`define DMT_RS_CONTROL 2'h2

// ==========================================================
// Reset values and field positions
`define DMT_CMD_RESET 8'h00
`define DMT_CNT_RESET 8'h00
`define DMT_CTRL_RESET 16'h0000
`define DMT_CTRL_PWD_BIT 0

// ==========================================================
// Status encodings
`define DMT_STAT_NORMAL 8'h00
`define DMT_STAT_DEBUG 8'h18
`define DMT_STAT_HWBKPT 8'h02
`define DMT_OS_NORMAL 2'h0
`define DMT_OS_STOP 2'h1
`define DMT_OS_DEBUG 2'h3

// ==========================================================
// Buffer shape
`define DMT_BUF_DEPTH 2

`endif

// [shared/dmt_pkg.sv]
// Types of the debug-module test access logic
package dmt_pkg;

  // ==========================================================
  // Test access port controller states
  typedef enum logic [3:0] {
    TAP_EXIT2_DR = 4'h0,
    TAP_EXIT1_DR = 4'h1,
    TAP_SHIFT_DR = 4'h2,
    TAP_PAUSE_DR = 4'h3,
    TAP_SEL_IR = 4'h4,
    TAP_UPDATE_DR = 4'h5,
    TAP_CAPTURE_DR = 4'h6,
    TAP_SEL_DR = 4'h7,
    TAP_EXIT2_IR = 4'h8,
    TAP_EXIT1_IR = 4'h9,
    TAP_SHIFT_IR = 4'ha,
    TAP_PAUSE_IR = 4'hb,
    TAP_IDLE = 4'hc,
    TAP_UPDATE_IR = 4'hd,
    TAP_CAPTURE_IR = 4'he,
    TAP_RESET = 4'hf
  } dmt_tap_state_type;

  // ==========================================================
  // Standard controller transitions
  function automatic dmt_tap_state_type dmt_tap_next(input dmt_tap_state_type st, input logic tms);
    dmt_tap_state_type nx;
    nx = TAP_RESET;
    case (st)
      TAP_RESET: nx = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: nx = tms ? TAP_SEL_IR : TAP_CAPTURE_DR;
      TAP_CAPTURE_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: nx = tms ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: nx = tms ? TAP_UPDATE_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: nx = tms ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: nx = tms ? TAP_UPDATE_DR : TAP_SHIFT_DR;
      TAP_UPDATE_DR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: nx = tms ? TAP_RESET : TAP_CAPTURE_IR;
      TAP_CAPTURE_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: nx = tms ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: nx = tms ? TAP_UPDATE_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: nx = tms ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: nx = tms ? TAP_UPDATE_IR : TAP_SHIFT_IR;
      TAP_UPDATE_IR: nx = tms ? TAP_SEL_DR : TAP_IDLE;
      default: nx = TAP_RESET;
    endcase
    return nx;
  endfunction : dmt_tap_next

endpackage : dmt_pkg

// [hdl/dmt_buf2.sv]
// Two-entry write buffer with valid and ready on both sides
`timescale 1ns/100ps
`include "dmt_defines.svh"

module dmt_buf2
  import dmt_pkg::*;
#(
  parameter int WIDTH = `DMT_SEL_W + `DMT_DR_W,
  parameter int DEPTH = `DMT_BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] wr_ptr_nxt;
  logic [PW-1:0] rd_ptr_r;
  logic [PW-1:0] rd_ptr_nxt;
  logic [PW:0] count_r;
  logic [PW:0] count_nxt;
  logic push;
  logic pop;

  // ==========================================================
  // Pointer and occupancy
  assign in_ready = (count_r != DEPTH[PW:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_ptr_nxt = wr_ptr_r;
    rd_ptr_nxt = rd_ptr_r;
    count_nxt = count_r;
    if (push) begin
      wr_ptr_nxt = (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(wr_ptr_r + 1'b1);
    end
    if (pop) begin
      rd_ptr_nxt = (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : PW'(rd_ptr_r + 1'b1);
    end
    if (push && !pop) begin
      count_nxt = (PW + 1)'(count_r + 1'b1);
    end else if (pop && !push) begin
      count_nxt = (PW + 1)'(count_r - 1'b1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (ce) begin
      wr_ptr_r <= wr_ptr_nxt;
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_nxt;
    end
  end

  // ==========================================================
  // Storage
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_entry
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          mem_r[gi] <= '0;
        end else if (ce && push && (wr_ptr_r == PW'(gi))) begin
          mem_r[gi] <= in_data;
        end
      end
    end
  endgenerate

endmodule : dmt_buf2

// [hdl/dmt_tap_access.sv]
// Debug-module access through the five-wire test access port
`timescale 1ns/100ps
`include "dmt_defines.svh"

// Behaviour
// (RQ1) Narrow registers sit in shifter low bits
// (RQ2) Counter write loads only low eight bits
// (RQ3) Probe ignores output during 16-bit writes
// (RQ4) Each command shift outputs debug status
// (RQ5) Zero opcode keeps 8-bit shifter selected
// (RQ6) Status 1A breakpoint halt, zero running
// (RQ7) Stop mode blocks all debug register access
// (RQ8) Last two IR bits are core status
// (RQ9) Probe may enter data path after polling
// (RQ10) Event pin low throughout debug mode
// (RQ11) Power-down bit stops breakpoint latching
// (RQ12) Access instruction at chip reset keeps module
// (RQ13) Other instruction at chip reset resets module
// (RQ14) Test reset with chip reset always resets
// (RQ15) Halt instruction during reset enters debug
// (RQ16) Probe preloads breakpoints before reset release
// (RQ17) Sixteen-state controller on dedicated pins
// (RQ18) 8-bit update writes command, capture status
// (RQ19) IR shift starts with one then zero
// (RQ20) Halt request latched until granted
// (RQ21) Standard transitions, test reset forces reset state
module dmt_tap_access
  import dmt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo,
  output logic tdo_oe,
  input wire logic chip_reset_n,
  input wire logic watchdog_reset,
  input wire logic core_debug_mode,
  input wire logic core_bkpt_halt,
  input wire logic core_stop_mode,
  output logic debug_event_out_n,
  output logic halt_request,
  output logic debug_power_down,
  output logic bkpt_latch_en,
  output logic debug_module_reset,
  output logic wr_out_valid,
  input wire logic wr_out_ready,
  output logic [`DMT_SEL_W-1:0] wr_out_sel,
  output logic [`DMT_DR_W-1:0] wr_out_data,
  output logic wr_buf_in_ready,
  output logic [`DMT_CMD_W-1:0] debug_command_reg,
  output logic [`DMT_CNT_W-1:0] debug_counter_reg,
  output logic [`DMT_DR_W-1:0] debug_control_reg,
  output logic [`DMT_IR_W-1:0] test_instruction_reg,
  output dmt_tap_state_type tap_state
);

  localparam int PIN_W = 5;
  localparam int P_TCK = 4;
  localparam int P_TMS = 3;
  localparam int P_TDI = 2;
  localparam int P_TRST = 1;
  localparam int P_CRST = 0;

  // ==========================================================
  // Opcode decoding
  function automatic logic op_has_xfer(input logic [`DMT_CMD_W-1:0] op);
    logic [`DMT_SEL_W-1:0] rs;
    rs = op[`DMT_OP_RS_MSB:`DMT_OP_RS_LSB];
    return (op[`DMT_OP_MID_MSB:`DMT_OP_MID_LSB] == '0) && ((rs == `DMT_RS_COUNTER) || (rs == `DMT_RS_CONTROL));
  endfunction : op_has_xfer

  function automatic logic op_is_write(input logic [`DMT_CMD_W-1:0] op);
    return op_has_xfer(op) && !op[`DMT_OP_RD_BIT];
  endfunction : op_is_write

  // ==========================================================
  // Pin synchronisers
  logic [PIN_W-1:0] sync1_r;
  logic [PIN_W-1:0] sync1_nxt;
  logic [PIN_W-1:0] sync2_r;
  logic [PIN_W-1:0] sync2_nxt;
  logic tck_d_r;
  logic tck_d_nxt;
  logic tck_rise;
  logic tck_fall;
  logic trst_act;
  logic chip_rst;

  always_comb begin
    sync1_nxt = {tck, tms, tdi, trst_n, chip_reset_n};
    sync2_nxt = sync1_r;
    tck_d_nxt = sync2_r[P_TCK];
  end

  // Pull-up defaults keep the port idle while the link is quiet
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_r <= 5'h0f;
      sync2_r <= 5'h0f;
      tck_d_r <= 1'b0;
    end else if (ce) begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      tck_d_r <= tck_d_nxt;
    end
  end

  assign tck_rise = sync2_r[P_TCK] & ~tck_d_r;
  assign tck_fall = ~sync2_r[P_TCK] & tck_d_r;
  assign trst_act = ~sync2_r[P_TRST];
  assign chip_rst = ~sync2_r[P_CRST] | watchdog_reset;

  // ==========================================================
  // Debug module state declarations
  logic [`DMT_CMD_W-1:0] cmd_r;
  logic [`DMT_CMD_W-1:0] cmd_nxt;
  logic sel16_r;
  logic sel16_nxt;
  logic [`DMT_CNT_W-1:0] cnt_r;
  logic [`DMT_CNT_W-1:0] cnt_nxt;
  logic [`DMT_DR_W-1:0] ctrl_r;
  logic [`DMT_DR_W-1:0] ctrl_nxt;
  logic dm_rst;
  logic dbg_sel;
  logic blocked;
  logic [`DMT_CMD_W-1:0] status_val;
  logic [1:0] os_val;
  logic [`DMT_DR_W-1:0] read_val;

  assign blocked = core_stop_mode; // RQ7
  assign status_val = core_debug_mode ? (`DMT_STAT_DEBUG | (core_bkpt_halt ? `DMT_STAT_HWBKPT : `DMT_STAT_NORMAL))
                                      : `DMT_STAT_NORMAL; // RQ6
  assign os_val = core_debug_mode ? `DMT_OS_DEBUG : (core_stop_mode ? `DMT_OS_STOP : `DMT_OS_NORMAL);

  // Narrow registers read back zero-extended in the low bits
  always_comb begin
    read_val = '0;
    case (cmd_r[`DMT_OP_RS_MSB:`DMT_OP_RS_LSB])
      `DMT_RS_COUNTER: read_val = {{(`DMT_DR_W - `DMT_CNT_W){1'b0}}, cnt_r}; // RQ1
      `DMT_RS_CONTROL: read_val = ctrl_r;
      default: read_val = '0;
    endcase
  end

  // ==========================================================
  // Controller, instruction and data shifters
  dmt_tap_state_type state_r;
  dmt_tap_state_type state_nxt;
  logic [`DMT_IR_W-1:0] ir_r;
  logic [`DMT_IR_W-1:0] ir_nxt;
  logic [`DMT_IR_W-1:0] ir_sh_r;
  logic [`DMT_IR_W-1:0] ir_sh_nxt;
  logic [`DMT_DR_W-1:0] dr_sh_r;
  logic [`DMT_DR_W-1:0] dr_sh_nxt;
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_oe_r;
  logic tdo_oe_nxt;
  logic upd_dr_evt;
  logic upd_ir_evt;

  assign dbg_sel = (ir_r == `DMT_IR_DEBUG_ACCESS);

  always_comb begin
    state_nxt = state_r;
    ir_nxt = ir_r;
    ir_sh_nxt = ir_sh_r;
    dr_sh_nxt = dr_sh_r;
    tdo_nxt = tdo_r;
    tdo_oe_nxt = tdo_oe_r;
    upd_dr_evt = 1'b0;
    upd_ir_evt = 1'b0;
    if (trst_act) begin
      state_nxt = TAP_RESET; // RQ21
      ir_nxt = `DMT_IR_IDCODE;
      tdo_oe_nxt = 1'b0;
    end else if (tck_rise) begin
      state_nxt = dmt_tap_next(state_r, sync2_r[P_TMS]); // RQ17
      case (state_r)
        TAP_RESET: begin
          ir_nxt = `DMT_IR_IDCODE;
        end
        TAP_CAPTURE_IR: begin
          ir_sh_nxt = {os_val, `DMT_IR_CAPTURE_LOW}; // RQ8 RQ19
        end
        TAP_SHIFT_IR: begin
          ir_sh_nxt = {sync2_r[P_TDI], ir_sh_r[`DMT_IR_W-1:1]};
        end
        TAP_UPDATE_IR: begin
          ir_nxt = ir_sh_r;
          upd_ir_evt = 1'b1;
        end
        TAP_CAPTURE_DR: begin
          if (!dbg_sel || blocked) begin
            dr_sh_nxt = '0; // RQ7
          end else if (!sel16_r) begin
            dr_sh_nxt = {{(`DMT_DR_W - `DMT_CMD_W){1'b0}}, status_val}; // RQ4 RQ18
          end else if (op_is_write(cmd_r)) begin
            dr_sh_nxt = '0; // RQ3
          end else begin
            dr_sh_nxt = read_val; // RQ1
          end
        end
        TAP_SHIFT_DR: begin
          if (dbg_sel && sel16_r) begin
            dr_sh_nxt = {sync2_r[P_TDI], dr_sh_r[`DMT_DR_W-1:1]};
          end else if (dbg_sel) begin
            dr_sh_nxt[`DMT_CMD_W-1:0] = {sync2_r[P_TDI], dr_sh_r[`DMT_CMD_W-1:1]};
          end else begin
            dr_sh_nxt[0] = sync2_r[P_TDI];
          end
        end
        TAP_UPDATE_DR: begin
          upd_dr_evt = 1'b1;
        end
        default: begin
          ir_nxt = ir_r;
        end
      endcase
    end else if (tck_fall) begin
      tdo_oe_nxt = (state_r == TAP_SHIFT_IR) || (state_r == TAP_SHIFT_DR);
      tdo_nxt = (state_r == TAP_SHIFT_IR) ? ir_sh_r[0] : dr_sh_r[0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_r <= TAP_RESET;
      ir_r <= `DMT_IR_IDCODE;
      ir_sh_r <= '0;
      dr_sh_r <= '0;
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (ce) begin
      state_r <= state_nxt;
      ir_r <= ir_nxt;
      ir_sh_r <= ir_sh_nxt;
      dr_sh_r <= dr_sh_nxt;
      tdo_r <= tdo_nxt;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // ==========================================================
  // Write buffer between the shifter and the register file
  logic buf_in_valid;
  logic buf_in_ready;
  logic buf_out_valid;
  logic [`DMT_SEL_W+`DMT_DR_W-1:0] buf_out_data;
  logic drain;

  // A full buffer drops the word; probe pacing keeps this rare
  assign buf_in_valid = ce & upd_dr_evt & dbg_sel & sel16_r & ~blocked & ~dm_rst & op_is_write(cmd_r);
  assign drain = buf_out_valid & wr_out_ready;

  dmt_buf2 #(
    .WIDTH(`DMT_SEL_W + `DMT_DR_W),
    .DEPTH(`DMT_BUF_DEPTH)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n & ~dm_rst),
    .ce(ce),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data({cmd_r[`DMT_OP_RS_MSB:`DMT_OP_RS_LSB], dr_sh_r}),
    .out_valid(buf_out_valid),
    .out_ready(wr_out_ready),
    .out_data(buf_out_data)
  );

  // ==========================================================
  // Debug module registers
  // Module reset follows chip reset unless access is held without test reset
  assign dm_rst = ~rst_n | (chip_rst & ((ir_r != `DMT_IR_DEBUG_ACCESS) | trst_act)); // RQ12 RQ13 RQ14

  always_comb begin
    cmd_nxt = cmd_r;
    sel16_nxt = sel16_r;
    cnt_nxt = cnt_r;
    ctrl_nxt = ctrl_r;
    if (upd_dr_evt && dbg_sel && !blocked) begin
      if (!sel16_r) begin
        cmd_nxt = dr_sh_r[`DMT_CMD_W-1:0]; // RQ18
        sel16_nxt = op_has_xfer(dr_sh_r[`DMT_CMD_W-1:0]); // RQ5
      end else begin
        sel16_nxt = 1'b0;
      end
    end
    if (drain) begin
      case (buf_out_data[`DMT_SEL_W+`DMT_DR_W-1:`DMT_DR_W])
        `DMT_RS_COUNTER: cnt_nxt = buf_out_data[`DMT_CNT_W-1:0]; // RQ2
        `DMT_RS_CONTROL: ctrl_nxt = buf_out_data[`DMT_DR_W-1:0];
        default: cnt_nxt = cnt_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (dm_rst) begin
      cmd_r <= `DMT_CMD_RESET;
      sel16_r <= 1'b0;
      cnt_r <= `DMT_CNT_RESET;
      ctrl_r <= `DMT_CTRL_RESET;
    end else if (ce) begin
      cmd_r <= cmd_nxt;
      sel16_r <= sel16_nxt;
      cnt_r <= cnt_nxt;
      ctrl_r <= ctrl_nxt;
    end
  end

  // ==========================================================
  // Halt latch and debug event pin
  logic halt_r;
  logic halt_nxt;
  logic de_n_r;
  logic de_n_nxt;
  logic halt_set;

  // Halt survives module reset so it is granted at chip reset release
  assign halt_set = (ir_nxt == `DMT_IR_HALT_REQ) & (upd_ir_evt | chip_rst); // RQ15 RQ20

  always_comb begin
    halt_nxt = halt_r;
    if (halt_set) begin
      halt_nxt = 1'b1; // RQ20
    end else if (core_debug_mode) begin
      halt_nxt = 1'b0;
    end
    de_n_nxt = ~core_debug_mode; // RQ10
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      halt_r <= 1'b0;
      de_n_r <= 1'b1;
    end else if (ce) begin
      halt_r <= halt_nxt;
      de_n_r <= de_n_nxt;
    end
  end

  // ==========================================================
  // Outputs
  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign debug_event_out_n = de_n_r;
  assign halt_request = halt_r;
  assign debug_power_down = ctrl_r[`DMT_CTRL_PWD_BIT]; // RQ11
  assign bkpt_latch_en = ~ctrl_r[`DMT_CTRL_PWD_BIT] & ~dm_rst; // RQ11
  assign debug_module_reset = dm_rst;
  assign wr_out_valid = buf_out_valid;
  assign wr_out_sel = buf_out_data[`DMT_SEL_W+`DMT_DR_W-1:`DMT_DR_W];
  assign wr_out_data = buf_out_data[`DMT_DR_W-1:0];
  assign wr_buf_in_ready = buf_in_ready;
  assign debug_command_reg = cmd_r;
  assign debug_counter_reg = cnt_r;
  assign debug_control_reg = ctrl_r;
  assign test_instruction_reg = ir_r;
  assign tap_state = state_r;

endmodule : dmt_tap_access

// [tb/dmt_tap_access_sva.sv]
// Assertion checker for the debug-module test access logic
`timescale 1ns/100ps
`include "dmt_defines.svh"

module dmt_tap_access_sva
  import dmt_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic trst_n,
  input wire logic tdo_oe,
  input wire logic chip_reset_n,
  input wire logic core_debug_mode,
  input wire logic debug_event_out_n,
  input wire logic halt_request,
  input wire logic debug_power_down,
  input wire logic bkpt_latch_en,
  input wire logic debug_module_reset,
  input wire logic wr_out_valid,
  input wire logic wr_out_ready,
  input wire logic [`DMT_SEL_W-1:0] wr_out_sel,
  input wire logic [`DMT_DR_W-1:0] wr_out_data,
  input wire logic [`DMT_CNT_W-1:0] debug_counter_reg,
  input wire logic [`DMT_IR_W-1:0] test_instruction_reg,
  input wire dmt_tap_state_type tap_state
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========
  // Reset windows
  // Five cycles cover the two-flop pin synchronisers
  sequence s_chip_other;
    (ce && !chip_reset_n && test_instruction_reg != `DMT_IR_DEBUG_ACCESS)[*5];
  endsequence
  sequence s_both_resets;
    (ce && !trst_n && !chip_reset_n)[*5];
  endsequence
  sequence s_access_held;
    (ce && trst_n && test_instruction_reg == `DMT_IR_DEBUG_ACCESS)[*5];
  endsequence

  // ==========
  // Properties
  property p_event_low;
    (ce && core_debug_mode) ##1 core_debug_mode |-> !debug_event_out_n;
  endproperty
  a_event_low: assert property (p_event_low) else $error("event pin high in debug mode");
  property p_event_high;
    (ce && !core_debug_mode) |=> debug_event_out_n;
  endproperty
  a_event_high: assert property (p_event_high) else $error("event pin low outside debug mode");
  property p_pwd;
    debug_power_down |-> !bkpt_latch_en;
  endproperty
  a_pwd: assert property (p_pwd) else $error("breakpoint latching while powered down");
  property p_cnt_low;
    (ce && wr_out_valid && wr_out_ready && wr_out_sel == `DMT_RS_COUNTER && !debug_module_reset)
      |=> {8'h00, debug_counter_reg} == ($past(wr_out_data) & 16'h00ff);
  endproperty
  a_cnt_low: assert property (p_cnt_low) else $error("counter not loaded from low byte");
  property p_chip_other;
    s_chip_other |-> debug_module_reset;
  endproperty
  a_chip_other: assert property (p_chip_other) else $error("module kept at chip reset");
  property p_access_keep;
    s_access_held |-> !debug_module_reset;
  endproperty
  a_access_keep: assert property (p_access_keep) else $error("module reset under access code");
  property p_both_resets;
    s_both_resets |-> debug_module_reset;
  endproperty
  a_both_resets: assert property (p_both_resets) else $error("module kept with test reset");
  property p_cnt_clear;
    (ce && debug_module_reset) |=> debug_counter_reg == `DMT_CNT_RESET;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter survived module reset");
  property p_trst_tap;
    (ce && !trst_n)[*5] |-> tap_state == TAP_RESET && !tdo_oe;
  endproperty
  a_trst_tap: assert property (p_trst_tap) else $error("controller not held in reset");
  property p_halt_hold;
    (ce && halt_request && !core_debug_mode) |=> halt_request;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt request lost before grant");
  property p_wr_hold;
    (ce && wr_out_valid && !wr_out_ready && !debug_module_reset) |=> wr_out_valid && $stable(wr_out_data);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word changed while stalled");
endmodule : dmt_tap_access_sva

bind dmt_tap_access dmt_tap_access_sva i_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .trst_n(trst_n), .tdo_oe(tdo_oe),
  .chip_reset_n(chip_reset_n), .core_debug_mode(core_debug_mode), .debug_event_out_n(debug_event_out_n),
  .halt_request(halt_request), .debug_power_down(debug_power_down), .bkpt_latch_en(bkpt_latch_en),
  .debug_module_reset(debug_module_reset), .wr_out_valid(wr_out_valid), .wr_out_ready(wr_out_ready),
  .wr_out_sel(wr_out_sel), .wr_out_data(wr_out_data), .debug_counter_reg(debug_counter_reg),
  .test_instruction_reg(test_instruction_reg), .tap_state(tap_state)
);

// [tb/dmt_probe.sv]
// Behavioural debug probe on the test access port
`timescale 1ns/100ps

module dmt_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ==========
  // Idle pin levels follow the pull resistors
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end

  // ==========
  // Bit steps and scans
  task automatic step(input logic ms, input logic di, output logic do_bit);
    tms = ms;
    tdi = di;
    #80 tck = 1'b1;
    do_bit = tdo_oe ? tdo : 1'bx;
    #80 tck = 1'b0;
  endtask : step

  task automatic to_idle();
    logic b;
    repeat (5) step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask : to_idle

  // Idle to idle; clock stands low between scans
  task automatic scan(input logic is_ir, input int n, input logic [15:0] din, output logic [15:0] dout);
    logic b;
    dout = 16'h0000;
    step(1'b1, 1'b1, b);
    if (is_ir) begin
      step(1'b1, 1'b1, b);
    end
    step(1'b0, 1'b1, b);
    step(1'b0, 1'b1, b);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      dout[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
    #200;
  endtask : scan
endmodule : dmt_probe

// [tb/tb_top.sv]
// Self-checking bench for the debug-module test access logic
`timescale 1ns/100ps
`include "dmt_defines.svh"

module tb_top
  import dmt_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n, ce, tck, tms, tdi, trst_n, tdo, tdo_oe, chip_reset_n, watchdog_reset;
  logic core_debug_mode, core_bkpt_halt, core_stop_mode, debug_event_out_n, halt_request;
  logic debug_power_down, bkpt_latch_en, debug_module_reset, wr_out_valid, wr_out_ready, wr_buf_in_ready;
  logic [`DMT_SEL_W-1:0] wr_out_sel;
  logic [`DMT_DR_W-1:0] wr_out_data;
  logic [`DMT_CMD_W-1:0] debug_command_reg;
  logic [`DMT_CNT_W-1:0] debug_counter_reg;
  logic [`DMT_DR_W-1:0] debug_control_reg;
  logic [`DMT_IR_W-1:0] test_instruction_reg;
  dmt_tap_state_type tap_state;
  logic [15:0] o;
  int error_cnt = 0;
  int num_checks = 0;
  typedef struct packed {
    logic dbg;
    logic bkpt;
    logic stp;
    logic [3:0] ir_out;
    logic [7:0] stat;
  } dmt_row_type;
  dmt_row_type rows [4] = '{'{1'b0, 1'b0, 1'b0, 4'h1, 8'h00}, '{1'b1, 1'b0, 1'b0, 4'hd, 8'h18},
                            '{1'b1, 1'b1, 1'b0, 4'hd, 8'h1a}, '{1'b0, 1'b0, 1'b1, 4'h5, 8'h00}};

  always #10 clk_sys = ~clk_sys;

  dmt_probe i_probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo), .tdo_oe(tdo_oe));

  dmt_tap_access i_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe(tdo_oe), .chip_reset_n(chip_reset_n), .watchdog_reset(watchdog_reset),
    .core_debug_mode(core_debug_mode), .core_bkpt_halt(core_bkpt_halt), .core_stop_mode(core_stop_mode),
    .debug_event_out_n(debug_event_out_n), .halt_request(halt_request), .debug_power_down(debug_power_down),
    .bkpt_latch_en(bkpt_latch_en), .debug_module_reset(debug_module_reset), .wr_out_valid(wr_out_valid),
    .wr_out_ready(wr_out_ready), .wr_out_sel(wr_out_sel), .wr_out_data(wr_out_data),
    .wr_buf_in_ready(wr_buf_in_ready), .debug_command_reg(debug_command_reg),
    .debug_counter_reg(debug_counter_reg), .debug_control_reg(debug_control_reg),
    .test_instruction_reg(test_instruction_reg), .tap_state(tap_state)
  );

  // ==========
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected bit at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [7:0] op, input logic [15:0] d);
    i_probe.scan(1'b0, 8, {8'h00, op}, o);
    i_probe.scan(1'b0, 16, d, o);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] op, input logic [15:0] exp);
    i_probe.scan(1'b0, 8, {8'h00, op}, o);
    i_probe.scan(1'b0, 16, 16'h0000, o);
    chk_val(o, exp);
  endtask : rd_reg

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // Scans need about a twelfth of this
  initial begin
    #1000000;
    error_cnt++;
    final_report();
  end

  // ==========
  // Sequence
  initial begin
    {ce, chip_reset_n, wr_out_ready} = 3'h7;
    {rst_n, watchdog_reset, core_debug_mode, core_bkpt_halt, core_stop_mode} = 5'h00;
    tick(11);
    chk_val({12'h000, tap_state}, {12'h000, TAP_RESET});
    chk_bit(debug_event_out_n, 1'b1);
    tick(1);
    rst_n = 1'b1;
    tick(3);
    i_probe.to_idle();
    foreach (rows[k]) begin
      tick(1);
      {core_debug_mode, core_bkpt_halt, core_stop_mode} = {rows[k].dbg, rows[k].bkpt, rows[k].stp};
      i_probe.scan(1'b1, 4, 16'h0006, o);
      chk_val(o, {12'h000, rows[k].ir_out});
      i_probe.scan(1'b0, 8, 16'h0000, o);
      chk_val(o, {8'h00, rows[k].stat});
      i_probe.scan(1'b0, 8, 16'h0000, o);
      chk_val(o, {8'h00, rows[k].stat});
      chk_bit(debug_event_out_n, ~rows[k].dbg);
    end
    tick(1);
    {core_debug_mode, core_bkpt_halt, core_stop_mode} = 3'h0;
    wr_reg(8'h01, 16'h1203);
    chk_val({8'h00, debug_counter_reg}, 16'h0003);
    chk_val({8'h00, debug_command_reg}, 16'h0001);
    rd_reg(8'h81, 16'h0003);
    wr_reg(8'h02, 16'h0001);
    chk_bit(bkpt_latch_en, 1'b0);
    rd_reg(8'h82, 16'h0001);
    wr_reg(8'h02, 16'h0000);
    chk_bit(bkpt_latch_en, 1'b1);
    // Stalled receiver: two words wait, a third is dropped
    tick(1);
    wr_out_ready = 1'b0;
    wr_reg(8'h01, 16'h0005);
    wr_reg(8'h01, 16'h0007);
    chk_bit(wr_buf_in_ready, 1'b0);
    wr_reg(8'h01, 16'h0009);
    chk_val({8'h00, debug_counter_reg}, 16'h0003);
    tick(1);
    wr_out_ready = 1'b1;
    tick(6);
    chk_val({8'h00, debug_counter_reg}, 16'h0007);
    chk_bit(wr_out_valid, 1'b0);
    watchdog_reset = 1'b1;
    tick(4);
    chk_bit(debug_module_reset, 1'b0);
    watchdog_reset = 1'b0;
    chk_val({8'h00, debug_counter_reg}, 16'h0007);
    i_probe.scan(1'b1, 4, 16'h000f, o);
    tick(1);
    chip_reset_n = 1'b0;
    tick(6);
    chk_bit(debug_module_reset, 1'b1);
    chk_val({8'h00, debug_counter_reg}, 16'h0000);
    i_probe.trst_n = 1'b0;
    tick(6);
    chk_val({12'h000, tap_state}, {12'h000, TAP_RESET});
    i_probe.trst_n = 1'b1;
    tick(5);
    i_probe.to_idle();
    i_probe.scan(1'b1, 4, 16'h0006, o);
    wr_reg(8'h01, 16'h0022);
    chk_val({8'h00, debug_counter_reg}, 16'h0022);
    i_probe.scan(1'b1, 4, 16'h0007, o);
    chk_bit(halt_request, 1'b1);
    tick(1);
    chip_reset_n = 1'b1;
    tick(6);
    chk_bit(halt_request, 1'b1);
    {ce, core_debug_mode} = 2'h1;
    tick(4);
    chk_bit(debug_event_out_n, 1'b1);
    ce = 1'b1;
    tick(4);
    chk_bit(debug_event_out_n, 1'b0);
    chk_bit(halt_request, 1'b0);
    final_report();
  end
endmodule : tb_top
